// ==== verilog/calibration_and_excitation_regs.sv ====
// Functional notes
// - Offset word built from three byte registers
// - Offset word is signed twos complement
// - Offset shifted left to result's top
// - Offset subtracted before any gain step
// - Gain word built from three byte registers
// - Gain word is unsigned straight binary
// - Gain coefficient is word over 400000h
// - Offset-corrected result multiplied by coefficient
// - Gain word resets to 400000h, unity
// - Routing high nibble places source b
// - Routing low nibble places source a
// - Routing register resets to BBh
// - Magnitude high nibble sets source b current
// - Magnitude low nibble sets source a current
// - Magnitude register resets to 00h
`timescale 1ns/10ps
module calibration_and_excitation_regs (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic [31:0] raw_result_i,
    input wire logic raw_valid_i,
    output logic [31:0] corrected_o,
    output logic corrected_valid_o,
    output logic corr_saturated_o,
    output logic [10:0] source_a_pin_o,
    output logic [10:0] source_b_pin_o,
    output logic [11:0] source_a_current_ua_o,
    output logic [11:0] source_b_current_ua_o
);

    logic [7:0] offset_corr_byte_low;
    logic [7:0] offset_corr_byte_mid;
    logic [7:0] offset_corr_byte_high;
    logic [7:0] gain_corr_byte_low;
    logic [7:0] gain_corr_byte_mid;
    logic [7:0] gain_corr_byte_high;
    logic [23:0] offset_corr_value;
    logic [23:0] gain_corr_value;
    logic [7:0] current_source_routing;
    logic [7:0] current_source_magnitude;
    logic [3:0] source_a_pin_select;
    logic [3:0] source_b_pin_select;
    logic [3:0] source_a_current_select;
    logic [3:0] source_b_current_select;
    logic [2:0] status;
    logic [2:0] status_clear;
    logic pin_rsvd_flag;
    logic mag_rsvd_flag;
    logic sat_flag;
    logic [31:0] last_result;
    logic [7:0] next_rdata;
    logic pin_rsvd_seen;
    logic mag_rsvd_seen;

    cal_corr_if corr_bus ();

    // Codes 0..9 are analog_input_0..9, 10 is analog_common_input
    function automatic logic [10:0] pin_onehot(input logic [3:0] code);
        logic [10:0] v;
        v = '0;
        if (code < cal_pkg::PIN_NONE) begin
            v = 11'h001 << code;
        end
        return v;
    endfunction

    function automatic logic wr_hit(input logic [7:0] a);
        return wr_i && (addr_i == a);
    endfunction

    // True when either nibble holds a code above the last legal one
    function automatic logic has_rsvd(input logic [7:0] w,
            input logic [3:0] last);
        return (w[7:4] > last) || (w[3:0] > last);
    endfunction

    assign offset_corr_value = {
        offset_corr_byte_high,
        offset_corr_byte_mid,
        offset_corr_byte_low
    };
    assign gain_corr_value = {
        gain_corr_byte_high,
        gain_corr_byte_mid,
        gain_corr_byte_low
    };

    assign source_b_pin_select = current_source_routing[
        cal_pkg::SRC_B_LSB +: cal_pkg::NIB_W];
    assign source_a_pin_select = current_source_routing[
        cal_pkg::SRC_A_LSB +: cal_pkg::NIB_W];
    assign source_b_current_select = current_source_magnitude[
        cal_pkg::SRC_B_LSB +: cal_pkg::NIB_W];
    assign source_a_current_select = current_source_magnitude[
        cal_pkg::SRC_A_LSB +: cal_pkg::NIB_W];

    // Live words feed the datapath; a multi-byte update can be seen
    // half done by one conversion, so software should update between
    // conversions or accept one odd sample.
    assign corr_bus.raw = raw_result_i;
    assign corr_bus.raw_valid = raw_valid_i;
    assign corr_bus.offset = offset_corr_value;
    assign corr_bus.gain = gain_corr_value;

    cal_corrector u_corrector (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .bus(corr_bus.core)
    );

    assign corrected_o = corr_bus.corrected;
    assign corrected_valid_o = corr_bus.corrected_valid;
    assign corr_saturated_o = corr_bus.saturated;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            offset_corr_byte_low <= cal_pkg::OFFSET_RESET[7:0];
        end else if (wr_hit(cal_pkg::OFFSET_LOW_ADDR)) begin
            offset_corr_byte_low <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            offset_corr_byte_mid <= cal_pkg::OFFSET_RESET[15:8];
        end else if (wr_hit(cal_pkg::OFFSET_MID_ADDR)) begin
            offset_corr_byte_mid <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            offset_corr_byte_high <= cal_pkg::OFFSET_RESET[23:16];
        end else if (wr_hit(cal_pkg::OFFSET_HIGH_ADDR)) begin
            offset_corr_byte_high <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            gain_corr_byte_low <= cal_pkg::GAIN_RESET[7:0];
        end else if (wr_hit(cal_pkg::GAIN_LOW_ADDR)) begin
            gain_corr_byte_low <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            gain_corr_byte_mid <= cal_pkg::GAIN_RESET[15:8];
        end else if (wr_hit(cal_pkg::GAIN_MID_ADDR)) begin
            gain_corr_byte_mid <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            gain_corr_byte_high <= cal_pkg::GAIN_RESET[23:16];
        end else if (wr_hit(cal_pkg::GAIN_HIGH_ADDR)) begin
            gain_corr_byte_high <= wdata_i;
        end
    end

    // Reserved codes are stored as written so readback is exact
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            current_source_routing <= cal_pkg::ROUTING_RESET;
        end else if (wr_hit(cal_pkg::ROUTING_ADDR)) begin
            current_source_routing <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            current_source_magnitude <= cal_pkg::MAGNITUDE_RESET;
        end else if (wr_hit(cal_pkg::MAGNITUDE_ADDR)) begin
            current_source_magnitude <= wdata_i;
        end
    end

    // Kept in a process so the strobes inside wr_hit are in its sensitivity
    always_comb begin
        pin_rsvd_seen = 1'b0;
        mag_rsvd_seen = 1'b0;
        status_clear = 3'h0;
        if (wr_hit(cal_pkg::ROUTING_ADDR)) begin
            pin_rsvd_seen = has_rsvd(wdata_i, cal_pkg::PIN_NONE);
        end
        if (wr_hit(cal_pkg::MAGNITUDE_ADDR)) begin
            mag_rsvd_seen = has_rsvd(wdata_i, cal_pkg::MAG_LAST);
        end
        if (wr_hit(cal_pkg::STATUS_ADDR)) begin
            status_clear = wdata_i[2:0];
        end
    end

    // Sticky flags, cleared by writing one; a new event beats the clear
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_rsvd_flag <= 1'b0;
        end else if (pin_rsvd_seen) begin
            pin_rsvd_flag <= 1'b1;
        end else if (status_clear[cal_pkg::ST_PIN_RSVD]) begin
            pin_rsvd_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mag_rsvd_flag <= 1'b0;
        end else if (mag_rsvd_seen) begin
            mag_rsvd_flag <= 1'b1;
        end else if (status_clear[cal_pkg::ST_MAG_RSVD]) begin
            mag_rsvd_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sat_flag <= 1'b0;
        end else if (corr_bus.corrected_valid && corr_bus.saturated) begin
            sat_flag <= 1'b1;
        end else if (status_clear[cal_pkg::ST_SATURATED]) begin
            sat_flag <= 1'b0;
        end
    end

    always_comb begin
        status = '0;
        status[cal_pkg::ST_PIN_RSVD] = pin_rsvd_flag;
        status[cal_pkg::ST_MAG_RSVD] = mag_rsvd_flag;
        status[cal_pkg::ST_SATURATED] = sat_flag;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            last_result <= '0;
        end else if (corr_bus.corrected_valid) begin
            last_result <= corr_bus.corrected;
        end
    end

    // Reserved routing codes leave the source unconnected
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            source_a_pin_o <= '0;
        end else begin
            source_a_pin_o <= pin_onehot(source_a_pin_select);
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            source_b_pin_o <= '0;
        end else begin
            source_b_pin_o <= pin_onehot(source_b_pin_select);
        end
    end

    // Reserved magnitude codes decode to zero current
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            source_a_current_ua_o <= '0;
        end else begin
            source_a_current_ua_o <=
                cal_pkg::mag_to_ua(source_a_current_select);
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            source_b_current_ua_o <= '0;
        end else begin
            source_b_current_ua_o <=
                cal_pkg::mag_to_ua(source_b_current_select);
        end
    end

    always_comb begin
        next_rdata = 8'h00;
        case (addr_i)
            cal_pkg::OFFSET_LOW_ADDR: begin
                next_rdata = offset_corr_byte_low;
            end
            cal_pkg::OFFSET_MID_ADDR: begin
                next_rdata = offset_corr_byte_mid;
            end
            cal_pkg::OFFSET_HIGH_ADDR: begin
                next_rdata = offset_corr_byte_high;
            end
            cal_pkg::GAIN_LOW_ADDR: begin
                next_rdata = gain_corr_byte_low;
            end
            cal_pkg::GAIN_MID_ADDR: begin
                next_rdata = gain_corr_byte_mid;
            end
            cal_pkg::GAIN_HIGH_ADDR: begin
                next_rdata = gain_corr_byte_high;
            end
            cal_pkg::ROUTING_ADDR: begin
                next_rdata = current_source_routing;
            end
            cal_pkg::MAGNITUDE_ADDR: begin
                next_rdata = current_source_magnitude;
            end
            cal_pkg::STATUS_ADDR: begin
                next_rdata = {5'h00, status};
            end
            cal_pkg::RESULT_B0_ADDR: begin
                next_rdata = last_result[7:0];
            end
            cal_pkg::RESULT_B1_ADDR: begin
                next_rdata = last_result[15:8];
            end
            cal_pkg::RESULT_B2_ADDR: begin
                next_rdata = last_result[23:16];
            end
            cal_pkg::RESULT_B3_ADDR: begin
                next_rdata = last_result[31:24];
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    // Data is shown only in the cycle after the read strobe
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            rdata_o <= next_rdata;
        end else begin
            rdata_o <= 8'h00;
        end
    end

endmodule

// ==== verilog/cal_pkg.sv ====
package cal_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int RAW_W = 32;
    localparam int WORD_W = 24;
    localparam int NIB_W = 4;
    localparam int PIN_W = 11;
    localparam int UA_W = 12;
    localparam int EXT_W = 35;

    localparam logic [7:0] OFFSET_LOW_ADDR = 8'h07;
    localparam logic [7:0] OFFSET_MID_ADDR = 8'h08;
    localparam logic [7:0] OFFSET_HIGH_ADDR = 8'h09;
    localparam logic [7:0] GAIN_LOW_ADDR = 8'h0a;
    localparam logic [7:0] GAIN_MID_ADDR = 8'h0b;
    localparam logic [7:0] GAIN_HIGH_ADDR = 8'h0c;
    localparam logic [7:0] ROUTING_ADDR = 8'h0d;
    localparam logic [7:0] MAGNITUDE_ADDR = 8'h0e;
    localparam logic [7:0] STATUS_ADDR = 8'h20;
    localparam logic [7:0] RESULT_B0_ADDR = 8'h21;
    localparam logic [7:0] RESULT_B1_ADDR = 8'h22;
    localparam logic [7:0] RESULT_B2_ADDR = 8'h23;
    localparam logic [7:0] RESULT_B3_ADDR = 8'h24;

    localparam logic [23:0] OFFSET_RESET = 24'h000000;
    localparam logic [23:0] GAIN_RESET = 24'h400000;
    localparam logic [7:0] ROUTING_RESET = 8'hbb;
    localparam logic [7:0] MAGNITUDE_RESET = 8'h00;

    localparam int SRC_B_LSB = 4;
    localparam int SRC_A_LSB = 0;
    localparam logic [3:0] PIN_NONE = 4'hb;
    localparam logic [3:0] MAG_LAST = 4'ha;

    localparam int ST_PIN_RSVD = 0;
    localparam int ST_MAG_RSVD = 1;
    localparam int ST_SATURATED = 2;

    localparam int OFFSET_ALIGN = RAW_W - WORD_W;
    localparam int GAIN_SHIFT = 22;

    function automatic logic is_ovf(input logic signed [EXT_W-1:0] v);
        return v[EXT_W-1:RAW_W-1] != {(EXT_W-RAW_W+1){v[EXT_W-1]}};
    endfunction

    function automatic logic [31:0] sat32(input logic signed [EXT_W-1:0] v);
        if (is_ovf(v)) begin
            return v[EXT_W-1] ? 32'h80000000 : 32'h7fffffff;
        end
        return v[31:0];
    endfunction

    function automatic logic [UA_W-1:0] mag_to_ua(input logic [3:0] c);
        case (c)
            4'h1: return 12'h032;
            4'h2: return 12'h064;
            4'h3: return 12'h0fa;
            4'h4: return 12'h1f4;
            4'h5: return 12'h2ee;
            4'h6: return 12'h3e8;
            4'h7: return 12'h5dc;
            4'h8: return 12'h7d0;
            4'h9: return 12'h9c4;
            4'ha: return 12'hbb8;
            default: return 12'h000;
        endcase
    endfunction

endpackage

// ==== verilog/cal_corr_if.sv ====
`timescale 1ns/10ps
interface cal_corr_if;
    logic [31:0] raw;
    logic raw_valid;
    logic [23:0] offset;
    logic [23:0] gain;
    logic [31:0] corrected;
    logic corrected_valid;
    logic saturated;

    modport ctrl (
        output raw, raw_valid, offset, gain,
        input corrected, corrected_valid, saturated
    );
    modport core (
        input raw, raw_valid, offset, gain,
        output corrected, corrected_valid, saturated
    );
endinterface

// ==== verilog/cal_corrector.sv ====
`timescale 1ns/10ps
module cal_corrector (
    input wire logic clk_i,
    input wire logic arst_n_i,
    cal_corr_if.core bus
);

    logic signed [31:0] aligned;
    logic signed [32:0] diff;
    logic signed [31:0] diff_q;
    logic sat1;
    logic valid1;
    logic signed [56:0] prod;
    logic signed [cal_pkg::EXT_W-1:0] scaled;
    logic signed [cal_pkg::EXT_W-1:0] diff_ext;

    // Offset sits in the top bits so one LSB is 2^8 result LSBs
    assign aligned = $signed({bus.offset, {cal_pkg::OFFSET_ALIGN{1'b0}}});
    assign diff = $signed({bus.raw[31], bus.raw}) - {aligned[31], aligned};
    assign diff_ext = {{2{diff[32]}}, diff};

    // Gain word is unsigned; 400000h is 2^22, so dividing is a shift
    assign prod = diff_q * $signed({1'b0, bus.gain});
    assign scaled = prod[56:cal_pkg::GAIN_SHIFT];

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            diff_q <= '0;
            sat1 <= 1'b0;
            valid1 <= 1'b0;
        end else begin
            valid1 <= bus.raw_valid;
            if (bus.raw_valid) begin
                diff_q <= cal_pkg::sat32(diff_ext);
                sat1 <= cal_pkg::is_ovf(diff_ext);
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bus.corrected <= '0;
            bus.corrected_valid <= 1'b0;
            bus.saturated <= 1'b0;
        end else begin
            bus.corrected_valid <= valid1;
            if (valid1) begin
                bus.corrected <= cal_pkg::sat32(scaled);
                bus.saturated <= sat1 | cal_pkg::is_ovf(scaled);
            end
        end
    end

endmodule

// ==== testbench/cal_assertions.sv ====
`timescale 1ns/10ps
module cal_assertions (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic [31:0] raw_result_i,
    input wire logic raw_valid_i,
    input wire logic [31:0] corrected_o,
    input wire logic corrected_valid_o,
    input wire logic corr_saturated_o,
    input wire logic [10:0] source_a_pin_o,
    input wire logic [10:0] source_b_pin_o,
    input wire logic [11:0] source_a_current_ua_o,
    input wire logic [11:0] source_b_current_ua_o
);
    localparam logic [11:0] UA [16] = '{12'h000, 12'h032, 12'h064, 12'h0fa,
        12'h1f4, 12'h2ee, 12'h3e8, 12'h5dc, 12'h7d0, 12'h9c4, 12'hbb8,
        12'h000, 12'h000, 12'h000, 12'h000, 12'h000};

    // Reserved codes leave the pin open
    function automatic logic [10:0] pin(input logic [3:0] c);
        return (c > 4'ha) ? 11'h000 : 11'h001 << c;
    endfunction

    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    valid_latency_a: assert property (
        raw_valid_i |-> ##2 corrected_valid_o)
        else $error("corrected result late");
    valid_cause_a: assert property (
        corrected_valid_o |-> $past(raw_valid_i, 2))
        else $error("corrected result without raw input");
    pin_a_follow_a: assert property (
        wr_i && addr_i == cal_pkg::ROUTING_ADDR ##2 1
        |-> source_a_pin_o == pin($past(wdata_i[3:0], 2)))
        else $error("source a pin wrong");
    pin_b_follow_a: assert property (
        wr_i && addr_i == cal_pkg::ROUTING_ADDR ##2 1
        |-> source_b_pin_o == pin($past(wdata_i[7:4], 2)))
        else $error("source b pin wrong");
    cur_a_follow_a: assert property (
        wr_i && addr_i == cal_pkg::MAGNITUDE_ADDR ##2 1
        |-> source_a_current_ua_o == UA[$past(wdata_i[3:0], 2)])
        else $error("source a current wrong");
    cur_b_follow_a: assert property (
        wr_i && addr_i == cal_pkg::MAGNITUDE_ADDR ##2 1
        |-> source_b_current_ua_o == UA[$past(wdata_i[7:4], 2)])
        else $error("source b current wrong");
    sat_value_a: assert property (
        corrected_valid_o && corr_saturated_o
        |-> corrected_o inside {32'h7fffffff, 32'h80000000})
        else $error("saturated result not at a limit");
    pins_onehot_a: assert property (
        $onehot0(source_a_pin_o) && $onehot0(source_b_pin_o))
        else $error("source pin not one-hot");
endmodule

bind calibration_and_excitation_regs cal_assertions cal_assertions_inst (.*);

// ==== testbench/tb.sv ====
`timescale 1ns/10ps
module tb;
    logic clk_i, arst_n_i, wr_i, rd_i, raw_valid_i;
    logic [7:0] addr_i, wdata_i, rdata_o;
    logic [31:0] raw_result_i, corrected_o;
    logic corrected_valid_o, corr_saturated_o;
    logic [10:0] source_a_pin_o, source_b_pin_o;
    logic [11:0] source_a_current_ua_o, source_b_current_ua_o;
    int failures = 0;
    int n_compared = 0;
    localparam logic [11:0] UA [16] = '{12'h000, 12'h032, 12'h064, 12'h0fa,
        12'h1f4, 12'h2ee, 12'h3e8, 12'h5dc, 12'h7d0, 12'h9c4, 12'hbb8,
        12'h000, 12'h000, 12'h000, 12'h000, 12'h000};
    localparam logic [7:0] RST [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h40, 8'hbb, 8'h00};

    calibration_and_excitation_regs calibration_and_excitation_regs_inst (.*);

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    function automatic logic [10:0] pin(input logic [3:0] c);
        return (c > 4'ha) ? 11'h000 : 11'h001 << c;
    endfunction

    // Reference arithmetic kept wide so overflow is seen before clipping
    function automatic logic [32:0] model(input logic [31:0] raw,
            input logic [23:0] off, input logic [23:0] g);
        logic signed [63:0] d;
        logic s;
        d = $signed({{32{raw[31]}}, raw})
            - $signed({{32{off[23]}}, off, 8'h00});
        s = 1'b0;
        for (int k = 0; k < 2; k++) begin
            if (k == 1) d = (d * $signed({40'h0, g})) >>> 22;
            s = s | (d > 64'sh7fffffff) | (d < -64'sh80000000);
            d = (d > 64'sh7fffffff) ? 64'sh7fffffff
                : (d < -64'sh80000000) ? -64'sh80000000 : d;
        end
        return {s, d[31:0]};
    endfunction

    task automatic chk(input logic [33:0] got, input logic [33:0] exp,
            input string what);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk({26'h0, rdata_o}, {26'h0, exp}, "read");
    endtask

    task automatic wr24(input logic [7:0] base, input logic [23:0] v);
        for (int i = 0; i < 3; i++) wr(base + 8'(i), v[8*i +: 8]);
        for (int i = 0; i < 3; i++) rd(base + 8'(i), v[8*i +: 8]);
    endtask

    // Two raw results back to back exercise the pipeline
    task automatic conv(input logic [23:0] off, input logic [23:0] g,
            input logic [31:0] r0, input logic [31:0] r1);
        logic [32:0] e0;
        logic [32:0] e1;
        e0 = model(r0, off, g);
        e1 = model(r1, off, g);
        wr24(cal_pkg::OFFSET_LOW_ADDR, off);
        wr24(cal_pkg::GAIN_LOW_ADDR, g);
        @(posedge clk_i);
        raw_valid_i <= 1'b1;
        raw_result_i <= r0;
        @(posedge clk_i);
        raw_result_i <= r1;
        @(posedge clk_i);
        raw_valid_i <= 1'b0;
        #1 chk({corrected_valid_o, corr_saturated_o, corrected_o},
            {1'b1, e0}, "first result");
        @(posedge clk_i);
        #1 chk({corrected_valid_o, corr_saturated_o, corrected_o},
            {1'b1, e1}, "second result");
        @(posedge clk_i);
        #1 chk({33'h0, corrected_valid_o}, 34'h0, "valid pulse");
        for (int i = 0; i < 4; i++) begin
            rd(cal_pkg::RESULT_B0_ADDR + 8'(i), e1[8*i +: 8]);
        end
    endtask

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #1000000;
        failures++;
        $display("[FAIL] %0t run did not finish", $time);
        close_out();
    end

    initial begin
        arst_n_i = 1'b0;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 8'h00;
        wdata_i = 8'h00;
        raw_valid_i = 1'b0;
        raw_result_i = 32'h0;
        repeat (6) @(posedge clk_i);
        arst_n_i <= 1'b1;
        foreach (RST[i]) rd(8'h07 + 8'(i), RST[i]);
        chk({12'h0, source_b_pin_o, source_a_pin_o}, 34'h0, "pins");
        chk({10'h0, source_b_current_ua_o, source_a_current_ua_o}, 34'h0,
            "currents");
        // Unmapped place must read as zero and ignore writes
        wr(8'h30, 8'h5a);
        rd(8'h30, 8'h00);
        $display("test reset done");
        for (int c = 0; c < 16; c++) begin
            wr(cal_pkg::ROUTING_ADDR, {4'(c), ~4'(c)});
            @(posedge clk_i);
            #1 chk({12'h0, source_b_pin_o, source_a_pin_o},
                {12'h0, pin(4'(c)), pin(~4'(c))}, "pins");
            rd(cal_pkg::ROUTING_ADDR, {4'(c), ~4'(c)});
            wr(cal_pkg::MAGNITUDE_ADDR, {4'(c), ~4'(c)});
            @(posedge clk_i);
            #1 chk({10'h0, source_b_current_ua_o, source_a_current_ua_o},
                {10'h0, UA[c], UA[15-c]}, "currents");
            rd(cal_pkg::MAGNITUDE_ADDR, {4'(c), ~4'(c)});
        end
        rd(cal_pkg::STATUS_ADDR, 8'h03);
        wr(cal_pkg::STATUS_ADDR, 8'h07);
        rd(cal_pkg::STATUS_ADDR, 8'h00);
        $display("test excitation done");
        conv(24'h000000, 24'h400000, 32'h12345678, 32'h80000000);
        conv(24'h000001, 24'h400000, 32'h00000100, 32'h7fffffff);
        conv(24'hffffff, 24'h400000, 32'h7fffffff, 32'h0);
        conv(24'h000000, 24'h800000, 32'h40000000, 32'hc0000000);
        conv(24'h000000, 24'h200000, 32'hfffffffd, 32'h3);
        conv(24'h800000, 24'hc00000, 32'h0, 32'h90000000);
        rd(cal_pkg::STATUS_ADDR, 8'h04);
        $display("test correction done");
        close_out();
    end
endmodule
